// file: include/doms_regs.vh
// register map, field positions, reset values and codes of the mode selector
`ifndef DOMS_REGS_VH
`define DOMS_REGS_VH

// ============================================================
// register byte offsets
`define DOMS_CTRL_OFS        8'h00
`define DOMS_ASSIGN_OFS      8'h04
`define DOMS_MODECMD_OFS     8'h08
`define DOMS_NETCMD_OFS      8'h0C
`define DOMS_STATUS_OFS      8'h10

// ============================================================
// control register fields
`define DOMS_CTRL_MSEL_LSB   0
`define DOMS_CTRL_MSEL_MSB   2
`define DOMS_CTRL_WSEL_LSB   4
`define DOMS_CTRL_WSEL_MSB   5
`define DOMS_MSEL_RESET      3'h0
`define DOMS_WSEL_RESET      2'h0
`define DOMS_WSEL_BLOCK      2'h1

// ============================================================
// input assignment: five six-bit function codes, one per terminal
`define DOMS_ASSIGN_W        6
`define DOMS_ASSIGN_RESET    30'h00000000
`define DOMS_FUNC_INTERLOCK  6'h0C

// ============================================================
// mode-change command codes and network command fields
`define DOMS_MCMD_TO_NET     2'h1
`define DOMS_MCMD_TO_EXT     2'h2
`define DOMS_NET_RUN_BIT     0
`define DOMS_NET_REV_BIT     1
`define DOMS_NET_FREQ_LSB    16
`define DOMS_NET_FREQ_MSB    31

// ============================================================
// mode-select values and operation mode codes
`define DOMS_MSEL_SWITCH     3'h0
`define DOMS_MSEL_PANEL      3'h1
`define DOMS_MSEL_EXTFIX     3'h2
`define DOMS_MSEL_COMB1      3'h3
`define DOMS_MSEL_COMB2      3'h4
`define DOMS_MSEL_RUNSW      3'h6
`define DOMS_MSEL_ILOCK      3'h7
`define DOMS_MODE_EXT        2'h0
`define DOMS_MODE_PANEL      2'h1
`define DOMS_MODE_NET        2'h2
`define DOMS_MODE_COMB       2'h3

`endif

// file: rtl/doms_mode_sel.v
// operation-mode selector of a motor drive with an apb register slave
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "doms_regs.vh"

module doms_mode_sel (
    input  wire        mclk_i,
    input  wire        reset_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    input  wire        forward_start_input_i,
    input  wire        reverse_start_input_i,
    input  wire        current_input_select_i,
    input  wire        output_stop_input_i,
    input  wire [4:0]  terminal_i,
    input  wire        multi_speed_valid_i,
    input  wire [15:0] multi_speed_freq_i,
    input  wire [15:0] pot_freq_i,
    input  wire [15:0] term4_freq_i,
    input  wire [15:0] panel_freq_i,
    input  wire        panel_fwd_key_i,
    input  wire        panel_rev_key_i,
    input  wire        panel_stop_reset_key_i,
    input  wire        panel_select_key_i,
    input  wire        panel_external_key_i,
    input  wire        panel_external_toggle_key_i,
    input  wire        alarm_i,
    input  wire        param_wr_req_i,
    input  wire        param_wr_is_msel_i,
    output wire        param_wr_ok_o,
    output reg  [1:0]  mode_o,
    output reg         run_o,
    output reg         dir_rev_o,
    output reg  [15:0] freq_o,
    output reg         output_stop_o,
    output reg         drive_reset_o
);

// ============================================================
// registers
reg  [2:0]  mode_select_param;
reg  [1:0]  write_select_param;
reg  [29:0] input_assign;
reg         net_run;
reg         net_rev;
reg  [15:0] net_freq;
reg  [1:0]  mode_cmd;
reg         panel_run;
reg         panel_rev;
reg         hold_valid;
reg         hold_run;
reg         hold_rev;
reg  [15:0] hold_freq;
reg         first_cycle;

// ============================================================
// apb decode
wire        wr_en  = psel_i & penable_i & pwrite_i;
wire        setup  = psel_i & ~penable_i;
wire        hit    = (paddr_i == `DOMS_CTRL_OFS)    |
                     (paddr_i == `DOMS_ASSIGN_OFS)  |
                     (paddr_i == `DOMS_MODECMD_OFS) |
                     (paddr_i == `DOMS_NETCMD_OFS)  |
                     (paddr_i == `DOMS_STATUS_OFS);

// zero wait states: read data is captured in the setup cycle
assign pready_o  = 1'b1;
assign pslverr_o = psel_i & penable_i & ~hit;

// ============================================================
// interlock source
wire [4:0] func_is_ilk;
genvar gi;
generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_assign
        assign func_is_ilk[gi] =
            (input_assign[gi*`DOMS_ASSIGN_W +: `DOMS_ASSIGN_W]
             == `DOMS_FUNC_INTERLOCK) & terminal_i[gi];
    end
endgenerate

reg  [4:0] assigned;
integer    k;
always @* begin
    for (k = 0; k < 5; k = k + 1) begin
        assigned[k] = (input_assign[k*`DOMS_ASSIGN_W +: `DOMS_ASSIGN_W]
                       == `DOMS_FUNC_INTERLOCK);
    end
end

wire ilk_mode  = (mode_select_param == `DOMS_MSEL_ILOCK);
// the output-stop input doubles as interlock when no terminal holds it
wire ilk_on    = (|assigned) ? (|func_is_ilk) : output_stop_input_i;
wire mrs_stop  = ~(|assigned) & output_stop_input_i;
wire ilk_off   = ilk_mode & ~ilk_on;

// ============================================================
// source values
wire ext_start = forward_start_input_i | reverse_start_input_i;
wire        ext_rev   = ~forward_start_input_i & reverse_start_input_i;
wire [15:0] ext_freq  = multi_speed_valid_i    ? multi_speed_freq_i :
                        current_input_select_i ? term4_freq_i :
                                                 pot_freq_i;
wire [15:0] comb1_freq = multi_speed_valid_i    ? multi_speed_freq_i :
                         current_input_select_i ? term4_freq_i :
                                                  panel_freq_i;

// ============================================================
// mode switching
wire req_panel = panel_select_key_i |
                 (panel_external_toggle_key_i & mode_o == `DOMS_MODE_EXT);
wire req_ext   = panel_external_key_i | (mode_cmd == `DOMS_MCMD_TO_EXT) |
                 (panel_external_toggle_key_i & mode_o == `DOMS_MODE_PANEL);
wire req_net   = (mode_cmd == `DOMS_MCMD_TO_NET);

reg        can_sw;
reg        net_only;
reg  [1:0] forced_mode;
reg        forced;
always @* begin
    can_sw      = 1'b0;
    net_only    = 1'b0;
    forced      = 1'b0;
    forced_mode = `DOMS_MODE_EXT;
    case (mode_select_param)
        `DOMS_MSEL_SWITCH: can_sw = ~run_o;
        `DOMS_MSEL_PANEL: begin
            forced      = 1'b1;
            forced_mode = `DOMS_MODE_PANEL;
        end
        `DOMS_MSEL_EXTFIX: begin
            can_sw   = ~run_o;
            net_only = 1'b1;
        end
        `DOMS_MSEL_COMB1,
        `DOMS_MSEL_COMB2: begin
            forced      = 1'b1;
            forced_mode = `DOMS_MODE_COMB;
        end
        `DOMS_MSEL_RUNSW: can_sw = 1'b1;
        `DOMS_MSEL_ILOCK: begin
            can_sw = ilk_on & ~run_o;
            forced = ~ilk_on;
        end
        default: can_sw = 1'b0;
    endcase
end

reg  [1:0] next_mode;
reg        next_hold_valid;
reg        next_hold_run;
reg        next_hold_rev;
reg [15:0] next_hold_freq;
always @* begin
    next_mode       = mode_o;
    next_hold_valid = hold_valid;
    next_hold_run   = hold_run;
    next_hold_rev   = hold_rev;
    next_hold_freq  = hold_freq;
    if (forced) begin
        // a forced mode (fixed panel, combined, external while interlock is off) ignores the switch requests; in forced external the start inputs drive it directly
        next_mode = forced_mode;
        if (forced_mode != mode_o)
            next_hold_valid = 1'b0;
    end else if (mode_o == `DOMS_MODE_COMB) begin
        next_mode = `DOMS_MODE_EXT;
    end else if (can_sw) begin
        case (mode_o)
            `DOMS_MODE_EXT: begin
                if (req_net | (req_panel & ~net_only)) begin
                    next_mode       = req_net ? `DOMS_MODE_NET
                                              : `DOMS_MODE_PANEL;
                    next_hold_valid = (mode_select_param
                                       == `DOMS_MSEL_RUNSW);
                    next_hold_run   = ext_start;
                    next_hold_rev   = ext_rev;
                    next_hold_freq  = ext_freq;
                end
            end
            `DOMS_MODE_PANEL: begin
                if (req_ext) begin
                    next_mode       = `DOMS_MODE_EXT;
                    next_hold_valid = 1'b0;
                end else if (req_net) begin
                    next_mode       = `DOMS_MODE_NET;
                    next_hold_valid = (mode_select_param
                                       == `DOMS_MSEL_RUNSW);
                    next_hold_run   = run_o;
                    next_hold_rev   = dir_rev_o;
                    next_hold_freq  = freq_o;
                end
            end
            `DOMS_MODE_NET: begin
                if (req_ext) begin
                    next_mode       = `DOMS_MODE_EXT;
                    next_hold_valid = 1'b0;
                end else if (req_panel & ~net_only) begin
                    next_mode       = `DOMS_MODE_PANEL;
                    next_hold_valid = (mode_select_param
                                       == `DOMS_MSEL_RUNSW);
                    next_hold_run   = run_o;
                    next_hold_rev   = dir_rev_o;
                    next_hold_freq  = freq_o;
                end
            end
            default: next_mode = `DOMS_MODE_EXT;
        endcase
    end
    // the stop key in panel mode or a network command write in network mode drops the carried-over values
    if ((mode_o == `DOMS_MODE_PANEL & panel_stop_reset_key_i) |
        (mode_o == `DOMS_MODE_NET & wr_en &
         paddr_i == `DOMS_NETCMD_OFS))
        next_hold_valid = 1'b0;
end

// ============================================================
// run, direction and frequency of the selected source
reg        next_run;
reg        next_rev;
reg [15:0] next_freq;
always @* begin
    next_run  = 1'b0;
    next_rev  = 1'b0;
    next_freq = 16'h0000;
    case (next_mode)
        `DOMS_MODE_EXT: begin
            next_run  = ext_start;
            next_rev  = ext_rev;
            next_freq = ext_freq;
        end
        `DOMS_MODE_PANEL: begin
            next_run  = next_hold_valid ? next_hold_run  : panel_run;
            next_rev  = next_hold_valid ? next_hold_rev  : panel_rev;
            next_freq = next_hold_valid ? next_hold_freq : panel_freq_i;
        end
        `DOMS_MODE_NET: begin
            next_run  = next_hold_valid ? next_hold_run  : net_run;
            next_rev  = next_hold_valid ? next_hold_rev  : net_rev;
            next_freq = next_hold_valid ? next_hold_freq : net_freq;
        end
        `DOMS_MODE_COMB: begin
            if (mode_select_param == `DOMS_MSEL_COMB1) begin
                next_run  = ext_start;
                next_rev  = ext_rev;
                next_freq = comb1_freq;
            end else begin
                next_run  = panel_run;
                next_rev  = panel_rev;
                next_freq = ext_freq;
            end
        end
        default: next_run = 1'b0;
    endcase
end

// output stop: in interlock mode, interlock on in external mode; otherwise the output-stop input while no terminal holds interlock
wire next_stop = (ilk_mode & ilk_on & next_mode == `DOMS_MODE_EXT) |
                 (~ilk_mode & mrs_stop);

// ============================================================
// parameter write gating
wire wr_allowed = ilk_off ? 1'b0
                          : (write_select_param != `DOMS_WSEL_BLOCK);
assign param_wr_ok_o = param_wr_req_i &
                       (param_wr_is_msel_i | wr_allowed);

// ============================================================
// state registers
always @(posedge mclk_i) begin
    if (reset_i) begin
        mode_select_param  <= `DOMS_MSEL_RESET;
        write_select_param <= `DOMS_WSEL_RESET;
        input_assign       <= `DOMS_ASSIGN_RESET;
        net_run            <= 1'b0;
        net_rev            <= 1'b0;
        net_freq           <= 16'h0000;
        mode_cmd           <= 2'h0;
        panel_run          <= 1'b0;
        panel_rev          <= 1'b0;
        hold_valid         <= 1'b0;
        hold_run           <= 1'b0;
        hold_rev           <= 1'b0;
        hold_freq          <= 16'h0000;
        mode_o             <= `DOMS_MODE_EXT;
        run_o              <= 1'b0;
        dir_rev_o          <= 1'b0;
        freq_o             <= 16'h0000;
        output_stop_o      <= 1'b0;
        drive_reset_o      <= 1'b0;
        prdata_o           <= 32'h00000000;
        first_cycle        <= 1'b1;
    end else begin
        first_cycle <= 1'b0;
        mode_cmd    <= 2'h0;
        if (wr_en) begin
            case (paddr_i)
                `DOMS_CTRL_OFS: begin
                    mode_select_param <=
                        pwdata_i[`DOMS_CTRL_MSEL_MSB:`DOMS_CTRL_MSEL_LSB];
                    if (wr_allowed)
                        write_select_param <=
                          pwdata_i[`DOMS_CTRL_WSEL_MSB:`DOMS_CTRL_WSEL_LSB];
                end
                `DOMS_ASSIGN_OFS: begin
                    if (wr_allowed)
                        input_assign <= pwdata_i[29:0];
                end
                `DOMS_MODECMD_OFS: mode_cmd <= pwdata_i[1:0];
                `DOMS_NETCMD_OFS: begin
                    net_run  <= pwdata_i[`DOMS_NET_RUN_BIT];
                    net_rev  <= pwdata_i[`DOMS_NET_REV_BIT];
                    net_freq <=
                        pwdata_i[`DOMS_NET_FREQ_MSB:`DOMS_NET_FREQ_LSB];
                end
                default: mode_cmd <= 2'h0;
            endcase
        end
        if (panel_stop_reset_key_i) begin
            panel_run <= 1'b0;
        end else if (panel_fwd_key_i | panel_rev_key_i) begin
            panel_run <= 1'b1;
            panel_rev <= ~panel_fwd_key_i;
        end
        hold_valid    <= next_hold_valid;
        hold_run      <= next_hold_run;
        hold_rev      <= next_hold_rev;
        hold_freq     <= next_hold_freq;
        // first cycle after reset settles the power-on mode only
        mode_o        <= first_cycle ?
                         (forced ? forced_mode : `DOMS_MODE_EXT)
                         : next_mode;
        run_o         <= next_run & ~next_stop;
        dir_rev_o     <= next_rev;
        freq_o        <= next_freq;
        output_stop_o <= next_stop;
        drive_reset_o <= alarm_i & panel_stop_reset_key_i;
        if (setup) begin
            case (paddr_i)
                `DOMS_CTRL_OFS:
                    prdata_o <= {26'h0000000, write_select_param,
                                 1'b0, mode_select_param};
                `DOMS_ASSIGN_OFS:
                    prdata_o <= {2'h0, input_assign};
                `DOMS_NETCMD_OFS:
                    prdata_o <= {net_freq, 14'h0000, net_rev, net_run};
                `DOMS_STATUS_OFS:
                    prdata_o <= {freq_o, 8'h00, hold_valid, ilk_on,
                                 output_stop_o, dir_rev_o, run_o,
                                 1'b0, mode_o};
                default:
                    prdata_o <= 32'h00000000;
            endcase
        end
    end
end

endmodule // doms_mode_sel

// file: tb/doms_checker.sv
// port assertions for the operation-mode selector
`timescale 1ns/1ps
module doms_checker (
    input wire        mclk_i,
    input wire        reset_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [7:0]  paddr_i,
    input wire [31:0] pwdata_i,
    input wire        output_stop_input_i,
    input wire [4:0]  terminal_i,
    input wire        alarm_i,
    input wire        panel_stop_reset_key_i,
    input wire        param_wr_req_i,
    input wire        param_wr_is_msel_i,
    input wire        param_wr_ok_o,
    input wire [1:0]  mode_o,
    input wire        run_o,
    input wire        output_stop_o,
    input wire        drive_reset_o
);
    // ============================================================
    // shadow of the settings written over the bus
    reg  [2:0]  msel;
    reg  [1:0]  wsel;
    reg  [29:0] asg;
    reg         hit, ilk;
    integer     k;
    wire        wr  = psel_i & penable_i & pwrite_i;
    wire        blk = (wsel == 2'h1) | ((msel == 3'h7) & ~ilk);
    always @(posedge mclk_i) begin
        if (reset_i) begin
            msel <= 3'h0;
            wsel <= 2'h0;
            asg  <= 30'h0;
        end else if (wr && paddr_i == 8'h00) begin
            msel <= pwdata_i[2:0];
            if (!blk) wsel <= pwdata_i[5:4];
        end else if (wr && paddr_i == 8'h04 && !blk) begin
            asg <= pwdata_i[29:0];
        end
    end
    // an assigned terminal replaces output stop as interlock
    always @* begin
        hit = 1'b0;
        ilk = 1'b0;
        for (k = 0; k < 5; k = k + 1) begin
            if (asg[6*k +: 6] == 6'h0C) begin
                hit = 1'b1;
                ilk = ilk | terminal_i[k];
            end
        end
        if (!hit) ilk = output_stop_input_i;
    end
    // ============================================================
    // assertions
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);
    a_fixed_panel: assert property (
        msel == 3'h1 && mode_o == 2'h1 |=> mode_o == 2'h1)
        else $error("fixed panel mode was left");
    a_comb_hold: assert property (
        (msel == 3'h3 || msel == 3'h4) && mode_o == 2'h3 |=> mode_o == 2'h3)
        else $error("combined mode was left");
    a_ilock_force: assert property (
        msel == 3'h7 && !ilk |=> mode_o == 2'h0)
        else $error("interlock off did not force external");
    a_ilock_stop: assert property (
        msel == 3'h7 && ilk && mode_o == 2'h0 |=> output_stop_o || |mode_o)
        else $error("no output stop with interlock on");
    a_stop_norun: assert property (
        output_stop_o |-> !run_o)
        else $error("running during output stop");
    a_ext_power: assert property (
        $fell(reset_i) |-> ##1 mode_o == 2'h0)
        else $error("not external after reset");
    a_drive_reset: assert property (
        drive_reset_o == $past(alarm_i && panel_stop_reset_key_i))
        else $error("drive reset not tied to alarm and stop key");
    a_wr_gate: assert property (
        param_wr_ok_o == (param_wr_req_i && (param_wr_is_msel_i || !blk)))
        else $error("parameter write gate wrong");
endmodule // doms_checker

// file: tb/doms_partner.sv
// panel keys, terminal switches and frequency sources around the selector
`timescale 1ns/1ps
module doms_partner (
    input  wire         mclk_i,
    output logic        fwd_o,
    output logic        rev_o,
    output logic        cur_sel_o,
    output logic        ostop_o,
    output logic [4:0]  term_o,
    output logic        alarm_o,
    output logic        ms_valid_o,
    output logic [15:0] ms_freq_o,
    output logic [15:0] pot_o,
    output logic [15:0] t4_o,
    output logic [15:0] pfreq_o,
    output logic [5:0]  keys_o
);
    initial begin
        set_sw(4'h0, 5'h00, 1'h0);
        set_fq(1'h0, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        keys_o = 6'h00;
    end
    // switch levels stay until the next call
    task set_sw(input logic [3:0] s, input logic [4:0] t, input logic a);
        {fwd_o, rev_o, cur_sel_o, ostop_o} <= s;
        term_o <= t;
        alarm_o <= a;
    endtask
    task set_fq(input logic v, input logic [15:0] m, p, t, f);
        {ms_valid_o, ms_freq_o, pot_o, t4_o, pfreq_o} <= {v, m, p, t, f};
    endtask
    // a key is held two edges so a one-edge glitch filter cannot lose it
    task press(input logic [2:0] i);
        keys_o <= 6'h01 << i;
        repeat (2) @(posedge mclk_i);
        keys_o <= 6'h00;
        @(posedge mclk_i);
    endtask
endmodule // doms_partner

// file: tb/drive_operation_mode_selector_test.sv
// self-checking bench for the operation-mode selector
`timescale 1ns/1ps
`include "doms_regs.vh"
module drive_operation_mode_selector_test;
    // ============================================================
    // signals
    logic        clk = 1'b0, rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rdat;
    logic        rerr, wr_req = 1'b0, wr_msel = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, wr_ok, run, dir, ostop, dres;
    wire         fwd, rev, csel, ost_in, msv, alarm;
    wire  [1:0]  mode;
    wire  [4:0]  term;
    wire  [5:0]  keys;
    wire  [15:0] freq, msf, pot, t4, pf;
    int          error_cnt = 0, n_compared = 0;
    initial forever #4 clk = ~clk;
    doms_mode_sel DUT (
        .mclk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .forward_start_input_i(fwd), .reverse_start_input_i(rev),
        .current_input_select_i(csel), .output_stop_input_i(ost_in),
        .terminal_i(term), .multi_speed_valid_i(msv),
        .multi_speed_freq_i(msf), .pot_freq_i(pot), .term4_freq_i(t4),
        .panel_freq_i(pf), .panel_fwd_key_i(keys[0]),
        .panel_rev_key_i(keys[1]), .panel_stop_reset_key_i(keys[2]),
        .panel_select_key_i(keys[3]), .panel_external_key_i(keys[4]),
        .panel_external_toggle_key_i(keys[5]), .alarm_i(alarm),
        .param_wr_req_i(wr_req), .param_wr_is_msel_i(wr_msel),
        .param_wr_ok_o(wr_ok), .mode_o(mode), .run_o(run),
        .dir_rev_o(dir), .freq_o(freq), .output_stop_o(ostop),
        .drive_reset_o(dres)
    );
    doms_partner u_partner (
        .mclk_i(clk), .fwd_o(fwd), .rev_o(rev), .cur_sel_o(csel),
        .ostop_o(ost_in), .term_o(term), .alarm_o(alarm),
        .ms_valid_o(msv), .ms_freq_o(msf), .pot_o(pot), .t4_o(t4),
        .pfreq_o(pf), .keys_o(keys)
    );
    // ============================================================
    // shared tasks
    task step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t ns: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    // packed as mode, run, reverse, frequency
    task look(input logic [1:0] m, input logic r, d, input logic [15:0] f);
        step(4);
        chk({12'h000, mode, run, dir, freq}, {12'h000, m, r, d, f});
    endtask
    task look_mode(input logic [1:0] m);
        step(4);
        chk({30'h0, mode}, {30'h0, m});
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do
            @(posedge clk);
        while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task ctrl(input logic [31:0] d);
        apb(1'h1, `DOMS_CTRL_OFS, d);
    endtask
    task rst_pulse;
        rst <= 1'h1;
        step(2);
        rst <= 1'h0;
        step(2);
    endtask
    task print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ============================================================
    // scenarios
    task t_bus;
        rst_pulse();
        ctrl(32'h00000016);
        apb(1'h0, `DOMS_CTRL_OFS, 32'h0);
        chk(rdat, 32'h00000016);
        wr_req <= 1'h1;
        look_mode(2'h0);
        chk({31'h0, wr_ok}, 32'h0);
        wr_msel <= 1'h1;
        step(2);
        chk({31'h0, wr_ok}, 32'h1);
        wr_req <= 1'h0;
        apb(1'h0, 8'h20, 32'h0);
        chk({rerr, rdat[30:0]}, 32'h80000000);
        $display("bus test done");
    endtask
    task t_fixed_comb;
        rst_pulse();
        ctrl(32'h00000001);
        look_mode(2'h1);
        u_partner.press(3'h4);
        u_partner.press(3'h5);
        look_mode(2'h1);
        rst_pulse();
        u_partner.set_fq(1'h0, 16'h0200, 16'h0055, 16'h0300, 16'h0100);
        u_partner.set_sw(4'h8, 5'h00, 1'h0);
        ctrl(32'h00000003);
        look(2'h3, 1'h1, 1'h0, 16'h0100);
        u_partner.press(3'h5);
        look(2'h3, 1'h1, 1'h0, 16'h0100);
        u_partner.set_fq(1'h1, 16'h0200, 16'h0055, 16'h0300, 16'h0100);
        look(2'h3, 1'h1, 1'h0, 16'h0200);
        u_partner.set_fq(1'h0, 16'h0200, 16'h0055, 16'h0300, 16'h0100);
        u_partner.set_sw(4'hA, 5'h00, 1'h0);
        look(2'h3, 1'h1, 1'h0, 16'h0300);
        u_partner.set_sw(4'h0, 5'h00, 1'h0);
        rst_pulse();
        ctrl(32'h00000004);
        u_partner.press(3'h0);
        u_partner.press(3'h5);
        look(2'h3, 1'h1, 1'h0, 16'h0055);
        u_partner.press(3'h1);
        look(2'h3, 1'h1, 1'h1, 16'h0055);
        $display("fixed and combined test done");
    endtask
    task t_switch;
        rst_pulse();
        u_partner.set_sw(4'h4, 5'h00, 1'h0);
        u_partner.set_fq(1'h0, 16'h0000, 16'h0123, 16'h0000, 16'h0000);
        ctrl(32'h00000006);
        look(2'h0, 1'h1, 1'h1, 16'h0123);
        u_partner.press(3'h3);
        look(2'h1, 1'h1, 1'h1, 16'h0123);
        u_partner.set_sw(4'h8, 5'h00, 1'h0);
        u_partner.set_fq(1'h0, 16'h0000, 16'h0077, 16'h0000, 16'h0000);
        apb(1'h1, `DOMS_MODECMD_OFS, 32'h00000001);
        look(2'h2, 1'h1, 1'h1, 16'h0123);
        u_partner.press(3'h3);
        look(2'h1, 1'h1, 1'h1, 16'h0123);
        u_partner.press(3'h4);
        look(2'h0, 1'h1, 1'h0, 16'h0077);
        apb(1'h1, `DOMS_MODECMD_OFS, 32'h00000001);
        u_partner.set_fq(1'h0, 16'h0000, 16'h0099, 16'h0000, 16'h0000);
        look(2'h2, 1'h1, 1'h0, 16'h0077);
        apb(1'h1, `DOMS_MODECMD_OFS, 32'h00000002);
        look(2'h0, 1'h1, 1'h0, 16'h0099);
        $display("switch-over test done");
    endtask
    task t_ilock;
        rst_pulse();
        u_partner.set_sw(4'h8, 5'h00, 1'h0);
        u_partner.set_fq(1'h0, 16'h0000, 16'h0042, 16'h0000, 16'h0000);
        ctrl(32'h00000007);
        wr_msel <= 1'h0;
        wr_req <= 1'h1;
        u_partner.press(3'h3);
        look(2'h0, 1'h1, 1'h0, 16'h0042);
        chk({31'h0, wr_ok}, 32'h0);
        u_partner.set_sw(4'h9, 5'h00, 1'h0);
        step(4);
        chk({30'h0, ostop, run}, 32'h2);
        chk({31'h0, wr_ok}, 32'h1);
        u_partner.set_sw(4'h8, 5'h00, 1'h0);
        look(2'h0, 1'h1, 1'h0, 16'h0042);
        u_partner.set_sw(4'h1, 5'h00, 1'h0);
        step(4);
        u_partner.press(3'h3);
        look_mode(2'h1);
        u_partner.set_sw(4'h9, 5'h00, 1'h0);
        step(4);
        u_partner.set_sw(4'h8, 5'h00, 1'h0);
        look(2'h0, 1'h1, 1'h0, 16'h0042);
        wr_req <= 1'h0;
        $display("interlock test done");
    endtask
    task t_assign;
        rst_pulse();
        u_partner.set_sw(4'h0, 5'h00, 1'h0);
        apb(1'h1, `DOMS_ASSIGN_OFS, 32'h0000C000);
        ctrl(32'h00000007);
        wr_req <= 1'h1;
        step(4);
        chk({31'h0, wr_ok}, 32'h0);
        u_partner.set_sw(4'h0, 5'h04, 1'h0);
        step(4);
        chk({31'h0, wr_ok}, 32'h1);
        u_partner.set_sw(4'h1, 5'h00, 1'h0);
        step(4);
        chk({31'h0, wr_ok}, 32'h0);
        wr_req <= 1'h0;
        u_partner.set_sw(4'h0, 5'h00, 1'h1);
        u_partner.press(3'h2);
        chk({31'h0, dres}, 32'h1);
        step(2);
        chk({31'h0, dres}, 32'h0);
        u_partner.set_sw(4'h0, 5'h00, 1'h0);
        $display("assignment and alarm test done");
    endtask
    // ============================================================
    // main sequence and watchdog
    initial begin
        step(16);
        rst <= 1'h0;
        step(2);
        t_bus();
        t_fixed_comb();
        t_switch();
        t_ilock();
        t_assign();
        print_verdict();
    end
    // run needs under 2000 cycles
    initial begin
        step(20000);
        error_cnt++;
        print_verdict();
    end
endmodule // drive_operation_mode_selector_test

bind doms_mode_sel doms_checker u_chk (
    .mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .output_stop_input_i(output_stop_input_i),
    .terminal_i(terminal_i), .alarm_i(alarm_i),
    .panel_stop_reset_key_i(panel_stop_reset_key_i),
    .param_wr_req_i(param_wr_req_i),
    .param_wr_is_msel_i(param_wr_is_msel_i),
    .param_wr_ok_o(param_wr_ok_o), .mode_o(mode_o), .run_o(run_o),
    .output_stop_o(output_stop_o), .drive_reset_o(drive_reset_o)
);
